/* rtl/sms_params.svh */
// constants for the spi port: mode codes, bit-timing counts, reset values
`ifndef SMS_PARAMS_SVH
`define SMS_PARAMS_SVH

// port mode field codes
`define SMS_MODE_DIV4 4'h0
`define SMS_MODE_DIV16 4'h1
`define SMS_MODE_DIV64 4'h2
`define SMS_MODE_TIMER 4'h3
`define SMS_MODE_SLAVE_SS 4'h4
`define SMS_MODE_SLAVE_FREE 4'h5
`define SMS_MODE_RELOAD 4'ha

// master half-period lengths in i_clk cycles
`define SMS_HALF_DIV4 6'h02
`define SMS_HALF_DIV16 6'h08
`define SMS_HALF_DIV64 6'h20

// master tick numbering: ticks 1..16 move the clock, tick 17 closes the byte
`define SMS_LAST_EDGE 5'h10
`define SMS_LAST_TICK 5'h11
`define SMS_SAMPLE_SPAN 5'h0e
`define SMS_SHIFT_SPAN 5'h0c
`define SMS_FIRST_SHIFT_EARLY 5'h02
`define SMS_FIRST_SHIFT_LATE 5'h03
`define SMS_EDGE_COUNT 5'h10

// slave bit counter
`define SMS_LAST_BIT 3'h7
`define SMS_BIT_ZERO 3'h0

// reset values
`define SMS_BYTE_RST 8'h00

`endif

/* rtl/sms_pkg.sv */
// types shared by the spi port
package sms_pkg;
  typedef enum logic {
    SMS_IDLE,
    SMS_RUN
  } sms_state_t;
  typedef logic [7:0] sms_byte_t;
endpackage

/* rtl/sms_sync3.sv */
// three-flop level synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
module sms_sync3 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);
  logic [W-1:0] st1;
  logic [W-1:0] st2;
  logic [W-1:0] st3;
  wire [W-1:0] agree = ~(st2 ^ st3);
  wire [W-1:0] next_level = (agree & st3) | (~agree & o_level);

  if (W < 1) begin : g_bad_width
    $error("sms_sync3: W must be at least 1");
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st1 <= '0;
      st2 <= '0;
      st3 <= '0;
      o_level <= '0;
    end else begin
      st1 <= i_async;
      st2 <= st1;
      st3 <= st2;
      o_level <= next_level;
    end
  end
endmodule

/* rtl/sms_spi_port.sv */
// spi port: master engine on i_clk, slave shifter on the link clock, software-side flags
`timescale 1ns/1ps
`include "sms_params.svh"
// Summary of operation
// - port stays inactive, pins released, until the port enable is set
// - mode, polarity, edge, phase, rate and slave-select use come from configuration inputs
// - after eight bits, msb first, byte goes to buffer; buffer-full and irq set
// - receive is double buffered; next byte shifts while buffer still holds last
// - buffer write during a transfer is dropped and write collision is set
// - while write collision is set, buffer writes do not complete
// - buffer read clears buffer-full; only a finished transfer sets it
// - shift register is reached only through the data buffer
// - master drives the clock and starts at once on a buffer write
// - master with data output disabled still samples input and loads bytes
// - master rate is clk/4, /16, /64, timer two half rate, or reload based
// - clock idle level follows the idle polarity in master and slave
// - with edge select set, output bit is valid before the first clock edge
// - master sample phase picks middle or end of the data output time
// - slave shifts on external clock and flags when the last bit latches
// - slave keeps shifting from the external clock while the processor sleeps
// - daisy-chained slave resends the received byte on the next burst
// - with overwrite enable, writes pass even when the last byte is unread
// - a buffer write loads the buffer and the master shift register; the slave shifter takes the buffer at bit zero
// - slave mode using the select pin is chosen by its mode code
// - select high in that mode releases the data output, even mid-byte
// - select high or enable cleared forces the bit counter to zero
module sms_spi_port #(
  parameter int RELOAD_W = 8
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_port_enable,
  input wire logic [3:0] i_port_mode_field,
  input wire logic i_clock_idle_polarity,
  input wire logic i_clock_edge_select,
  input wire logic i_sample_phase_select,
  input wire logic i_buffer_overwrite_enable,
  input wire logic [RELOAD_W-1:0] i_rate_reload,
  input wire logic i_timer_two,
  input wire logic i_sdo_disable,
  input wire logic i_buf_wr,
  input wire logic [7:0] i_buf_wdata,
  input wire logic i_buf_rd,
  input wire logic i_write_collision_flag_clr,
  input wire logic i_irq_clr,
  input wire logic i_sck,
  input wire logic i_sdi,
  input wire logic i_ss_n,
  output logic [7:0] o_buf_rdata,
  output logic o_buffer_full_flag,
  output logic o_serial_irq_flag,
  output logic o_write_collision_flag,
  output logic o_busy,
  output logic o_sck,
  output logic o_sck_oe,
  output logic o_sdo,
  output logic o_sdo_oe
);
  localparam int HALF_W = RELOAD_W + 2;

  if (RELOAD_W < 4 || RELOAD_W > 16) begin : g_bad_reload
    $error("sms_spi_port: RELOAD_W must lie in 4..16");
  end

  // half period of the master clock in i_clk cycles
  function automatic logic [HALF_W-1:0] half_count(input logic [3:0] mode, input logic [RELOAD_W-1:0] reload);
    logic [HALF_W-1:0] r;
    r = HALF_W'(`SMS_HALF_DIV4);
    if (mode == `SMS_MODE_DIV16) begin
      r = HALF_W'(`SMS_HALF_DIV16);
    end else if (mode == `SMS_MODE_DIV64) begin
      r = HALF_W'(`SMS_HALF_DIV64);
    end else if (mode == `SMS_MODE_RELOAD) begin
      r = HALF_W'({reload, 1'b0}) + HALF_W'(`SMS_HALF_DIV4);
    end
    return r;
  endfunction

  // true on ticks first, first+2, ... first+span
  function automatic logic on_step(input logic [4:0] k, input logic [4:0] first, input logic [4:0] span);
    return (k >= first) && (k <= first + span) && (k[0] == first[0]);
  endfunction

  // configuration, frozen while enabled
  logic en_q;
  logic [3:0] cfg_mode;
  logic cfg_ckp;
  logic cfg_cke;
  logic cfg_smp;
  logic cfg_buffer_overwrite_enable;
  logic [RELOAD_W-1:0] cfg_reload;

  // software-side state
  logic [7:0] data_buffer;
  logic bf;
  logic irq;
  logic write_collision_flag;
  logic busy_q;
  logic sck_oe_q;
  logic s_tog_seen;

  // master engine
  sms_pkg::sms_state_t m_state;
  logic [4:0] m_k;
  logic [HALF_W-1:0] m_div;
  logic [7:0] m_tx;
  logic [7:0] m_rx;
  logic m_sck;

  // slave engine, link clock domain
  logic [2:0] s_cnt;
  logic [7:0] shift_reg;
  logic s_busy;
  logic s_out;
  logic s_tog;
  logic [7:0] s_rx;

  logic [2:0] sy_level;

  wire cfg_slave = (cfg_mode == `SMS_MODE_SLAVE_SS) || (cfg_mode == `SMS_MODE_SLAVE_FREE);
  wire cfg_ss_used = (cfg_mode == `SMS_MODE_SLAVE_SS);
  wire m_busy = (m_state == sms_pkg::SMS_RUN);
  wire sdi_s = sy_level[0];
  wire s_busy_s = sy_level[1];
  wire s_tog_s = sy_level[2];

  // master timing
  wire [HALF_W-1:0] m_half = half_count(cfg_mode, cfg_reload);
  wire [HALF_W-1:0] m_half_last = m_half - HALF_W'(1);
  wire m_rate_hit = (cfg_mode == `SMS_MODE_TIMER) ? i_timer_two : (m_div == m_half_last);
  wire m_tick = m_busy && m_rate_hit;
  wire [4:0] m_k_next = m_k + 5'h01;
  wire m_done = m_tick && (m_k_next == `SMS_LAST_TICK);
  wire m_toggle = m_tick && (m_k_next <= `SMS_LAST_EDGE);
  // end-of-output sampling simply moves every sample one tick later
  wire [4:0] samp_first = 5'h01 + {4'h0, ~cfg_cke} + {4'h0, cfg_smp};
  wire [4:0] shift_first = cfg_cke ? `SMS_FIRST_SHIFT_EARLY : `SMS_FIRST_SHIFT_LATE;
  wire m_sample = m_tick && on_step(m_k_next, samp_first, `SMS_SAMPLE_SPAN);
  wire m_shift = m_tick && on_step(m_k_next, shift_first, `SMS_SHIFT_SPAN);
  wire [7:0] m_rx_next = {m_rx[6:0], sdi_s};
  wire [7:0] m_rx_final = m_sample ? m_rx_next : m_rx;

  // buffer writes
  wire busy_any = m_busy || (cfg_slave && s_busy_s);
  wire wr_hit = i_buf_wr && en_q;
  wire wr_collide = wr_hit && busy_any;
  wire wr_ok = wr_hit && !busy_any && !write_collision_flag && (cfg_buffer_overwrite_enable || !bf);

  // received bytes from either engine
  wire slv_done = en_q && cfg_slave && (s_tog_s != s_tog_seen);
  wire rx_load = m_done || slv_done;
  wire [7:0] rx_byte = m_done ? m_rx_final : s_rx;
  wire [7:0] next_buffer = rx_load ? rx_byte : (wr_ok ? i_buf_wdata : data_buffer);

  // slave domain: reset clears the bit counter, so a lost bit cannot carry over
  wire s_rst = ~en_q | ~cfg_slave | (cfg_ss_used & i_ss_n);
  // config is static while enabled, so folding polarity into the clock is glitch free
  wire slv_clk = i_sck ^ ~(cfg_ckp ^ cfg_cke);
  // first bit comes from the buffer, which after a byte holds that byte again
  wire [7:0] s_src = (s_cnt == `SMS_BIT_ZERO) ? data_buffer : shift_reg;
  wire [7:0] s_next = {s_src[6:0], i_sdi};
  wire s_sdo = ((s_cnt == `SMS_BIT_ZERO) && cfg_cke) ? data_buffer[7] : s_out;

  // pins: data output follows the select pin without a clock so it releases mid-byte
  assign o_sdo = cfg_slave ? s_sdo : m_tx[7];
  assign o_sdo_oe = en_q & ~i_sdo_disable & (~cfg_slave | ~(cfg_ss_used & i_ss_n));
  assign o_sck = m_sck;
  assign o_sck_oe = sck_oe_q;
  assign o_buf_rdata = data_buffer;
  assign o_buffer_full_flag = bf;
  assign o_serial_irq_flag = irq;
  assign o_write_collision_flag = write_collision_flag;
  assign o_busy = busy_q;

  sms_sync3 #(
    .W(3)
  ) u_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_async({s_tog, s_busy, i_sdi}),
    .o_level(sy_level)
  );

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      en_q <= 1'b0;
    end else begin
      en_q <= i_port_enable;
    end
  end

  // settings only move while the port is off
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cfg_mode <= `SMS_MODE_DIV4;
      cfg_ckp <= 1'b0;
      cfg_cke <= 1'b0;
      cfg_smp <= 1'b0;
      cfg_buffer_overwrite_enable <= 1'b0;
      cfg_reload <= '0;
    end else if (!en_q) begin
      cfg_mode <= i_port_mode_field;
      cfg_ckp <= i_clock_idle_polarity;
      cfg_cke <= i_clock_edge_select;
      cfg_smp <= i_sample_phase_select;
      cfg_buffer_overwrite_enable <= i_buffer_overwrite_enable;
      cfg_reload <= i_rate_reload;
    end
  end

  // flags: a set in the same cycle as a clear wins
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      data_buffer <= `SMS_BYTE_RST;
      bf <= 1'b0;
      irq <= 1'b0;
      write_collision_flag <= 1'b0;
      busy_q <= 1'b0;
      sck_oe_q <= 1'b0;
      s_tog_seen <= 1'b0;
    end else begin
      data_buffer <= next_buffer;
      bf <= rx_load | (bf & ~i_buf_rd);
      irq <= rx_load | (irq & ~i_irq_clr);
      write_collision_flag <= wr_collide | (write_collision_flag & ~i_write_collision_flag_clr);
      busy_q <= busy_any;
      sck_oe_q <= en_q & ~cfg_slave;
      s_tog_seen <= s_tog_s;
    end
  end

  // master sequencer
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      m_state <= sms_pkg::SMS_IDLE;
      m_k <= 5'h00;
      m_div <= '0;
      m_sck <= 1'b0;
    end else if (!en_q || cfg_slave) begin
      m_state <= sms_pkg::SMS_IDLE;
      m_k <= 5'h00;
      m_div <= '0;
      m_sck <= cfg_ckp;
    end else begin
      case (m_state)
        sms_pkg::SMS_IDLE: begin
          m_k <= 5'h00;
          m_div <= '0;
          m_sck <= cfg_ckp;
          if (wr_ok) begin
            m_state <= sms_pkg::SMS_RUN;
          end
        end
        sms_pkg::SMS_RUN: begin
          m_div <= m_tick ? '0 : m_div + HALF_W'(1);
          if (m_tick) begin
            m_k <= m_k_next;
          end
          if (m_toggle) begin
            m_sck <= ~m_sck;
          end
          if (m_done) begin
            m_state <= sms_pkg::SMS_IDLE;
          end
        end
        default: begin
          m_state <= sms_pkg::SMS_IDLE;
        end
      endcase
    end
  end

  // master data path; input keeps shifting even with the output pin released
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      m_tx <= `SMS_BYTE_RST;
      m_rx <= `SMS_BYTE_RST;
    end else begin
      if (wr_ok) begin
        m_tx <= i_buf_wdata;
      end else if (m_shift) begin
        m_tx <= {m_tx[6:0], 1'b0};
      end
      if (m_sample) begin
        m_rx <= m_rx_next;
      end
    end
  end

  // slave sample edge; runs with i_clk stopped, flag is raised once i_clk returns
  always_ff @(posedge slv_clk or posedge s_rst) begin
    if (s_rst) begin
      s_cnt <= `SMS_BIT_ZERO;
      shift_reg <= `SMS_BYTE_RST;
      s_busy <= 1'b0;
    end else begin
      s_cnt <= s_cnt + 3'h1;
      shift_reg <= s_next;
      s_busy <= (s_cnt != `SMS_LAST_BIT);
    end
  end

  // byte hand-off: data is held, the toggle tells the other domain
  always_ff @(posedge slv_clk or negedge en_q) begin
    if (!en_q) begin
      s_rx <= `SMS_BYTE_RST;
      s_tog <= 1'b0;
    end else if (s_cnt == `SMS_LAST_BIT) begin
      s_rx <= s_next;
      s_tog <= ~s_tog;
    end
  end

  // slave output edge, opposite to the sample edge
  always_ff @(negedge slv_clk or posedge s_rst) begin
    if (s_rst) begin
      s_out <= 1'b0;
    end else begin
      s_out <= s_src[7];
    end
  end

  // assertion helper: clock edges seen in the current master byte
  logic [4:0] hlp_edges;
  logic hlp_prev;
  always_ff @(posedge i_clk) begin
    if (i_srst || !m_busy) begin
      hlp_edges <= 5'h00;
    end else if (m_sck != hlp_prev) begin
      hlp_edges <= hlp_edges + 5'h01;
    end
    hlp_prev <= i_srst ? 1'b0 : m_sck;
  end

  property p_disabled_quiet;
    @(posedge i_clk) disable iff (i_srst)
    (!en_q && !i_port_enable) |=> (!o_sck_oe && !o_sdo_oe);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("pins driven while port disabled");

  property p_cfg_frozen;
    @(posedge i_clk) disable iff (i_srst)
    (en_q && $past(en_q)) |-> ($stable(cfg_mode) && $stable(cfg_ckp) && $stable(cfg_cke));
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("configuration moved while enabled");

  property p_rx_load_flags;
    @(posedge i_clk) disable iff (i_srst)
    rx_load |=> (o_buffer_full_flag && o_serial_irq_flag && o_buf_rdata == $past(rx_byte));
  endproperty
  a_rx_load_flags: assert property (p_rx_load_flags) else $error("received byte not loaded with flags");

  property p_collision;
    @(posedge i_clk) disable iff (i_srst)
    (wr_collide && !rx_load) |=> (o_write_collision_flag && o_buf_rdata == $past(o_buf_rdata));
  endproperty
  a_collision: assert property (p_collision) else $error("write during transfer not refused");

  property p_write_collision_flag_blocks;
    @(posedge i_clk) disable iff (i_srst)
    (write_collision_flag && i_buf_wr && !rx_load && !m_busy) |=> (o_buf_rdata == $past(o_buf_rdata) && !m_busy);
  endproperty
  a_write_collision_flag_blocks: assert property (p_write_collision_flag_blocks) else $error("write completed while collision set");

  property p_bf_read;
    @(posedge i_clk) disable iff (i_srst)
    (i_buf_rd && !rx_load) |=> !o_buffer_full_flag;
  endproperty
  a_bf_read: assert property (p_bf_read) else $error("read did not clear buffer full");

  property p_master_start;
    @(posedge i_clk) disable iff (i_srst)
    (wr_ok && !cfg_slave) |=> (m_busy && m_tx == $past(i_buf_wdata) && o_buf_rdata == $past(i_buf_wdata));
  endproperty
  a_master_start: assert property (p_master_start) else $error("master write did not start transfer");

  property p_eight_clocks;
    @(posedge i_clk) disable iff (i_srst)
    m_done |=> (hlp_edges == `SMS_EDGE_COUNT && o_sck == cfg_ckp);
  endproperty
  a_eight_clocks: assert property (p_eight_clocks) else $error("master byte without sixteen clock edges");

  property p_idle_level;
    @(posedge i_clk) disable iff (i_srst)
    (en_q && $past(en_q) && !cfg_slave && !m_busy) |-> (o_sck == cfg_ckp && o_sck_oe);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("master clock not at idle level");

  property p_first_bit;
    @(posedge i_clk) disable iff (i_srst)
    (m_busy && m_k == 5'h00 && !cfg_slave) |-> (o_sdo == o_buf_rdata[7]);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first bit not presented before clocking");

  property p_ss_release;
    @(posedge i_clk) disable iff (i_srst)
    (cfg_slave && cfg_ss_used && i_ss_n) |-> !o_sdo_oe;
  endproperty
  a_ss_release: assert property (p_ss_release) else $error("slave drove data with select high");
endmodule

/* dv/sms_far_model.sv */
// far-side spi model: slave for master runs, 15 ns master for slave runs
`timescale 1ns/1ps
module sms_far_model (
  input wire logic i_sck,
  input wire logic i_sck_oe,
  input wire logic i_sdo,
  output logic o_sdi,
  output logic o_sck,
  output logic o_ss_n
);
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;
  logic [7:0] edges = 8'h00;
  // set for edge select clear: sample on the falling edge, shift on every rising edge but the first
  logic late = 1'b0;
  initial begin
    o_sdi = 1'b0;
    o_sck = 1'b0; // idle level held before the port is enabled
    o_ss_n = 1'b1;
  end
  always @(posedge i_sck) begin
    if (i_sck_oe) begin
      if (!late) begin
        rx = {rx[6:0], i_sdo};
      end else if (edges != 8'h00) begin
        tx = {tx[6:0], ~tx[0]};
        o_sdi = tx[7];
      end
      edges = edges + 8'h01;
    end
  end
  always @(negedge i_sck) begin
    if (i_sck_oe) begin
      if (late) begin
        rx = {rx[6:0], i_sdo};
      end else begin
        tx = {tx[6:0], ~tx[0]};
        o_sdi = tx[7];
      end
    end
  end
  task automatic load(input logic [7:0] b);
    tx = b;
    o_sdi = b[7];
    edges = 8'h00;
  endtask
  // clock runs only inside the frame; a released data line shows the inverse
  task automatic burst(input logic [7:0] b, input int n);
    load(b);
    o_ss_n = 1'b0;
    #30;
    for (int i = 0; i < n; i++) begin
      #7.5 o_sck = 1'b1;
      rx = {rx[6:0], i_sdo};
      #7.5 o_sck = 1'b0;
      tx = {tx[6:0], ~tx[0]};
      o_sdi = tx[7];
    end
    #30 o_ss_n = 1'b1;
    o_sdi = ~o_sdi;
  endtask
endmodule

/* dv/test_sms_spi_port.sv */
// self-checking bench for the spi port: master runs, rates, slave bursts
`timescale 1ns/1ps
`include "sms_params.svh"
module test_sms_spi_port;
  logic i_clk, i_timer_two;
  logic i_srst = 1'b1;
  logic i_port_enable = 1'b0, i_clock_idle_polarity = 1'b0, i_sample_phase_select = 1'b0;
  logic i_buffer_overwrite_enable = 1'b0, i_sdo_disable = 1'b0, i_buf_wr = 1'b0, i_buf_rd = 1'b0;
  logic i_write_collision_flag_clr = 1'b0, i_irq_clr = 1'b0;
  logic i_clock_edge_select = 1'b1;
  logic [3:0] i_port_mode_field = 4'h0;
  logic [7:0] i_rate_reload = 8'h02;
  logic [7:0] i_buf_wdata = 8'h00;
  logic i_sck, i_sdi, i_ss_n;
  logic [7:0] o_buf_rdata;
  logic o_buffer_full_flag, o_serial_irq_flag, o_write_collision_flag, o_busy;
  logic o_sck, o_sck_oe, o_sdo, o_sdo_oe;
  int err_count = 0;
  int n_tests = 0;
  int tcnt = 0;
  sms_spi_port #(.RELOAD_W(8)) uut (.i_clk, .i_srst, .i_port_enable, .i_port_mode_field, .i_clock_idle_polarity,
    .i_clock_edge_select, .i_sample_phase_select, .i_buffer_overwrite_enable, .i_rate_reload, .i_timer_two,
    .i_sdo_disable, .i_buf_wr, .i_buf_wdata, .i_buf_rd, .i_write_collision_flag_clr, .i_irq_clr, .i_sck, .i_sdi, .i_ss_n,
    .o_buf_rdata, .o_buffer_full_flag, .o_serial_irq_flag, .o_write_collision_flag, .o_busy, .o_sck,
    .o_sck_oe, .o_sdo, .o_sdo_oe);
  sms_far_model far (.i_sck(o_sck), .i_sck_oe(o_sck_oe), .i_sdo(o_sdo), .o_sdi(i_sdi), .o_sck(i_sck),
    .o_ss_n(i_ss_n));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // one-cycle pulse every five cycles, so a timer-rate half period is five cycles
  always @(negedge i_clk) begin
    tcnt = (tcnt == 4) ? 0 : tcnt + 1;
    i_timer_two = (tcnt == 4);
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] b);
    @(negedge i_clk);
    i_buf_wr = 1'b1;
    i_buf_wdata = b;
    @(negedge i_clk);
    i_buf_wr = 1'b0;
  endtask
  task automatic clr(input logic r, input logic w, input logic q);
    @(negedge i_clk);
    {i_buf_rd, i_write_collision_flag_clr, i_irq_clr} = {r, w, q};
    @(negedge i_clk);
    {i_buf_rd, i_write_collision_flag_clr, i_irq_clr} = 3'h0;
  endtask
  // configuration is only taken while the port is off
  task automatic cfg(input logic [3:0] m, input logic clock_idle_polarity, input logic sample_phase_select, input logic buffer_overwrite_enable);
    @(negedge i_clk);
    i_port_enable = 1'b0;
    repeat (2) @(negedge i_clk);
    {i_port_mode_field, i_clock_idle_polarity, i_sample_phase_select, i_buffer_overwrite_enable} = {m, clock_idle_polarity, sample_phase_select, buffer_overwrite_enable};
    @(negedge i_clk);
    i_port_enable = 1'b1;
    repeat (3) @(negedge i_clk);
  endtask
  task automatic wait_done();
    repeat (2) @(negedge i_clk);
    chk("busy", 8'h01, {7'h00, o_busy});
    for (int k = 0; k < 2000 && o_busy !== 1'b0; k++) @(negedge i_clk);
    chk("done", 8'h00, {7'h00, o_busy});
  endtask
  task automatic wait_bf();
    for (int k = 0; k < 50 && o_buffer_full_flag !== 1'b1; k++) @(negedge i_clk);
  endtask
  task automatic t_master(input logic [7:0] tx, input logic [7:0] rx);
    far.load(rx);
    wr(tx);
    chk("sdo drive", {7'h00, ~i_sdo_disable}, {7'h00, o_sdo_oe});
    wait_done();
    chk("rx byte", rx, o_buf_rdata);
    chk("bf irq", 8'h03, {6'h00, o_buffer_full_flag, o_serial_irq_flag});
    chk("sck edges", 8'h08, far.edges);
    chk("sck idle", {7'h00, i_clock_idle_polarity}, {7'h00, o_sck});
    if (!i_sdo_disable) begin
      chk("sent byte", tx, far.rx);
    end
  endtask
  task automatic s_off();
    wr(8'haa);
    repeat (3) @(negedge i_clk);
    chk("off buffer", 8'h00, o_buf_rdata);
    chk("off enables", 8'h00, {6'h00, o_sck_oe, o_sdo_oe});
  endtask
  task automatic s_flags();
    cfg(`SMS_MODE_DIV16, 1'b0, 1'b0, 1'b0);
    far.load(8'h3c);
    wr(8'ha5);
    repeat (3) @(negedge i_clk);
    wr(8'h11);
    chk("collision", 8'h01, {7'h00, o_write_collision_flag});
    wait_done();
    chk("rx kept", 8'h3c, o_buf_rdata);
    chk("sent kept", 8'ha5, far.rx);
    wr(8'h22);
    repeat (3) @(negedge i_clk);
    chk("write with collision", 8'h3c, o_buf_rdata);
    clr(1'b0, 1'b1, 1'b0);
    wr(8'h22);
    repeat (3) @(negedge i_clk);
    chk("write while full", 8'h3c, o_buf_rdata);
    chk("collision cleared", 8'h00, {7'h00, o_write_collision_flag});
    clr(1'b1, 1'b0, 1'b1);
    chk("bf after read", 8'h00, {7'h00, o_buffer_full_flag});
    t_master(8'h22, 8'h77);
  endtask
  task automatic s_modes();
    cfg(`SMS_MODE_DIV16, 1'b0, 1'b0, 1'b1);
    t_master(8'he1, 8'h4b);
    t_master(8'h1e, 8'hb4);
    i_sdo_disable = 1'b1;
    t_master(8'h5a, 8'hc6);
    i_sdo_disable = 1'b0;
    cfg(`SMS_MODE_DIV16, 1'b0, 1'b1, 1'b1);
    t_master(8'h0f, 8'hf0);
    i_clock_edge_select = 1'b0;
    far.late = 1'b1;
    cfg(`SMS_MODE_DIV16, 1'b0, 1'b0, 1'b1);
    t_master(8'h3c, 8'hc3);
    i_clock_edge_select = 1'b1;
    far.late = 1'b0;
  endtask
  task automatic s_rates();
    logic [3:0] md [5];
    int half [5];
    int k;
    md = '{`SMS_MODE_DIV4, `SMS_MODE_DIV16, `SMS_MODE_DIV64, `SMS_MODE_TIMER, `SMS_MODE_RELOAD};
    half = '{2, 8, 32, 5, 6};
    for (int i = 0; i < 5; i++) begin
      cfg(md[i], i[0], 1'b0, 1'b1);
      far.load(8'h00);
      wr(8'h55);
      for (k = 0; k < 100 && o_sck === i_clock_idle_polarity; k++) @(negedge i_clk);
      for (k = 0; k < 100 && o_sck !== i_clock_idle_polarity; k++) @(negedge i_clk);
      chk("half period", half[i][7:0], k[7:0]);
      wait_done();
      chk("rate edges", 8'h08, far.edges);
      chk("rate idle", {7'h00, i_clock_idle_polarity}, {7'h00, o_sck});
    end
  endtask
  task automatic s_slave();
    cfg(`SMS_MODE_SLAVE_SS, 1'b0, 1'b0, 1'b1);
    clr(1'b1, 1'b0, 1'b1);
    wr(8'h96);
    far.burst(8'h5a, 8);
    wait_bf();
    chk("slave rx", 8'h5a, o_buf_rdata);
    chk("slave tx", 8'h96, far.rx);
    chk("slave irq", 8'h01, {7'h00, o_serial_irq_flag});
    clr(1'b1, 1'b0, 1'b1);
    far.burst(8'hc3, 8);
    wait_bf();
    chk("chain resend", 8'h5a, far.rx);
    chk("second byte", 8'hc3, o_buf_rdata);
    clr(1'b1, 1'b0, 1'b1);
    far.burst(8'hff, 4);
    #1;
    chk("sdo released", 8'h00, {7'h00, o_sdo_oe});
    repeat (10) @(negedge i_clk);
    far.burst(8'h81, 8);
    wait_bf();
    chk("realigned byte", 8'h81, o_buf_rdata);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge i_clk);
    i_srst = 1'b0;
    s_off();
    s_flags();
    s_modes();
    s_rates();
    s_slave();
    tally_and_finish();
  end
  // the whole run needs well under 10000 cycles
  initial begin
    #2000000;
    err_count++;
    $display("ERROR watchdog expected finish seen hang");
    tally_and_finish();
  end
endmodule
